/* inc/tcs_pkg.sv */
package tcs_pkg;
  localparam int          NUM_CH          = 8;
  localparam logic [19:0] ADDR_OVF_CH0    = 20'hF01A0;
  localparam logic [19:0] ADDR_OVF_CH7    = 20'hF01AE;
  localparam logic [19:0] ADDR_EN_STATUS  = 20'hF01B0;
  localparam logic [19:0] ADDR_START_TRIG = 20'hF01B2;
  localparam logic [19:0] ADDR_STOP_TRIG  = 20'hF01B4;
  localparam logic [19:0] ADDR_HI_BYTE    = 20'h00001;
  localparam logic [15:0] TRIG_MASK       = 16'h0AFF;
  localparam logic [15:0] EN_RESET        = 16'h0000;
  localparam logic [15:0] OVF_RESET       = 16'h0000;
  localparam logic [15:0] RD_RESET        = 16'h0000;
  localparam int          OVF_BIT         = 0;
  localparam int          UPPER_CH1_BIT   = 9;
  localparam int          UPPER_CH3_BIT   = 11;
  localparam logic [2:0]  MODE_INTERVAL   = 3'h0;
  localparam logic [2:0]  MODE_CAPTURE    = 3'h2;
  localparam logic [2:0]  MODE_EVENT      = 3'h3;
  localparam logic [2:0]  MODE_ONE_COUNT  = 3'h4;
  localparam logic [2:0]  MODE_CAP_ONE    = 3'h6;

  typedef struct packed {
    logic accept;
    logic notify;
  } tcs_start_t;

  function automatic logic tcs_is_capture(input logic [2:0] mode);
    return (mode == MODE_CAPTURE) || (mode == MODE_CAP_ONE);
  endfunction : tcs_is_capture

  function automatic logic tcs_is_one_shot(input logic [2:0] mode);
    return (mode == MODE_ONE_COUNT) || (mode == MODE_CAP_ONE);
  endfunction : tcs_is_one_shot
endpackage : tcs_pkg

/* inc/tcs_ovf_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tcs_ovf_if;
  logic [2:0] mode;
  logic       capture;
  logic       ovf_event;
  logic       flag;
  modport ctl  (output mode, output capture, output ovf_event, input flag);
  modport chan (input mode, input capture, input ovf_event, output flag);
endinterface : tcs_ovf_if
`default_nettype wire

/* verilog/tcs_ovf_chan.sv */
`timescale 1ns/1ns
`default_nettype none
module tcs_ovf_chan (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Channel link
  tcs_ovf_if.chan  ovf
);
  logic pending_r;
  logic flag_r;
  logic capt_mode;

  assign capt_mode = tcs_pkg::tcs_is_capture(ovf.mode);
  assign ovf.flag  = flag_r;

  // remember overflow
  // Overflow is only noted here; the visible flag waits for a capture.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pending_r <= 1'b0;
    end else if (!capt_mode || ovf.capture) begin
      pending_r <= 1'b0;
    end else if (ovf.ovf_event) begin
      pending_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_r <= tcs_pkg::OVF_RESET[tcs_pkg::OVF_BIT];
    end else if (capt_mode && ovf.capture) begin
      flag_r <= pending_r | ovf.ovf_event;
    end
  end

  property p_ovf_set;
    @(posedge clk_sys) disable iff (reset)
      (capt_mode && ovf.capture && (pending_r || ovf.ovf_event)) |=> flag_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("Overflow flag not set at capture.");

  property p_ovf_clear;
    @(posedge clk_sys) disable iff (reset)
      (capt_mode && ovf.capture && !pending_r && !ovf.ovf_event) |=> !flag_r;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("Overflow flag not cleared at clean capture.");

  property p_ovf_hold;
    @(posedge clk_sys) disable iff (reset)
      !(capt_mode && ovf.capture) |=> $stable(flag_r);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("Overflow flag moved without a capture.");

  property p_ovf_mode;
    @(posedge clk_sys) disable iff (reset)
      (ovf.capture && !capt_mode) |=> $stable(flag_r);
  endproperty
  a_ovf_mode: assert property (p_ovf_mode)
    else $error("Overflow flag moved outside capture modes.");

  c_ovf_set: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(flag_r));
endmodule : tcs_ovf_chan
`default_nettype wire

/* verilog/tcs_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tcs_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // CPU memory access
  input  wire logic [19:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_byte,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata_r,
  // Channel mode settings
  input  wire logic [7:0]  op_mode_bit2,
  input  wire logic [7:0]  op_mode_bit1,
  input  wire logic [7:0]  op_mode_bit0,
  input  wire logic [7:0]  start_behaviour_bit,
  // Counter datapath status
  input  wire logic [7:0]  counter_busy,
  input  wire logic [7:0]  capture_event,
  input  wire logic [7:0]  overflow_event,
  // Enable status
  output logic      [7:0]  channel_enable_flag,
  output logic             upper_half_enable_ch1,
  output logic             upper_half_enable_ch3,
  // Start actions
  output logic      [7:0]  channel_interrupt_r,
  output logic      [7:0]  channel_timer_output_chg_r,
  output logic      [7:0]  count_restart_r
);
  logic [15:0] en_r;
  logic [15:0] en_nxt;
  logic [15:0] start_bits;
  logic [15:0] stop_bits;
  logic [15:0] rd_word;
  logic [15:0] rdata_nxt;
  logic [19:0] word_addr;
  logic [19:0] ovf_off;
  logic [2:0]  ovf_idx;
  logic [7:0]  ovf_flag;
  logic [7:0]  accept;
  logic [7:0]  notify;
  logic [7:0]  irq_nxt;
  logic [7:0]  restart_nxt;

  // Trigger registers hold nothing; a write only produces pulses.
  function automatic logic [15:0] trig_bits(
    input logic [19:0] a,
    input logic [19:0] base,
    input logic        bw,
    input logic [15:0] d
  );
    logic [15:0] w;
    w = 16'h0000;
    if (a == base) begin
      w = bw ? {8'h00, d[7:0]} : d;
    end else if (bw && (a == base + tcs_pkg::ADDR_HI_BYTE)) begin
      w = {d[7:0], 8'h00};
    end
    return w & tcs_pkg::TRIG_MASK;
  endfunction : trig_bits

  function automatic tcs_pkg::tcs_start_t start_decide(
    input logic [2:0] mode,
    input logic       beh,
    input logic       busy
  );
    tcs_pkg::tcs_start_t d;
    d.accept = 1'b0;
    d.notify = 1'b0;
    case (mode)
      tcs_pkg::MODE_INTERVAL, tcs_pkg::MODE_CAPTURE: begin
        d.accept = 1'b1;
        d.notify = beh;
      end
      tcs_pkg::MODE_EVENT: begin
        d.accept = 1'b1;
      end
      tcs_pkg::MODE_ONE_COUNT, tcs_pkg::MODE_CAP_ONE: begin
        d.accept = !busy || beh;
      end
      // prohibited codes
      // A prohibited code still lets the enable flag set, but the counter
      // is never kicked, so a bad setting cannot start a count.
      default: begin
        d.accept = 1'b0;
      end
    endcase
    return d;
  endfunction : start_decide

  assign start_bits = cpu_wr ? trig_bits(cpu_addr, tcs_pkg::ADDR_START_TRIG,
                                         cpu_byte, cpu_wdata) : 16'h0000;
  assign stop_bits  = cpu_wr ? trig_bits(cpu_addr, tcs_pkg::ADDR_STOP_TRIG,
                                         cpu_byte, cpu_wdata) : 16'h0000;
  assign en_nxt     = (en_r | start_bits) & ~stop_bits;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      en_r <= tcs_pkg::EN_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  // per-channel flags
  // In split mode the low flags of channels 1 and 3 mean the lower half.
  assign channel_enable_flag = en_r[7:0];
  assign upper_half_enable_ch1 = en_r[tcs_pkg::UPPER_CH1_BIT];
  assign upper_half_enable_ch3 = en_r[tcs_pkg::UPPER_CH3_BIT];

  for (genvar n = 0; n < tcs_pkg::NUM_CH; n++) begin : g_ch
    tcs_pkg::tcs_start_t dec;
    logic [2:0]          mode;
    tcs_ovf_if           u_if ();

    assign mode = {op_mode_bit2[n], op_mode_bit1[n], op_mode_bit0[n]};
    assign dec  = start_decide(mode, start_behaviour_bit[n],
                               counter_busy[n]);
    assign accept[n]      = dec.accept;
    assign notify[n]      = dec.notify;
    assign u_if.mode      = mode;
    assign u_if.capture   = capture_event[n];
    assign u_if.ovf_event = overflow_event[n];
    assign ovf_flag[n]    = u_if.flag;

    tcs_ovf_chan u_ovf (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ovf     (u_if.chan)
    );

    property p_start_sets_en;
      @(posedge clk_sys) disable iff (reset)
        start_bits[n] |=> channel_enable_flag[n];
    endproperty
    a_start_sets_en: assert property (p_start_sets_en)
      else $error("Start trigger did not set the enable flag.");

    property p_stop_clears_en;
      @(posedge clk_sys) disable iff (reset)
        stop_bits[n] |=> !channel_enable_flag[n];
    endproperty
    a_stop_clears_en: assert property (p_stop_clears_en)
      else $error("Stop trigger did not clear the enable flag.");

    property p_irq_cause;
      @(posedge clk_sys) disable iff (reset)
        channel_interrupt_r[n] |->
          $past(start_bits[n]) && $past(start_behaviour_bit[n]) &&
          ($past(mode) == tcs_pkg::MODE_INTERVAL ||
           $past(mode) == tcs_pkg::MODE_CAPTURE);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
      else $error("Start interrupt without a notifying start.");

    property p_irq_given;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && start_behaviour_bit[n] &&
         (mode == tcs_pkg::MODE_INTERVAL || mode == tcs_pkg::MODE_CAPTURE))
        |=> channel_interrupt_r[n] && channel_timer_output_chg_r[n];
    endproperty
    a_irq_given: assert property (p_irq_given)
      else $error("Notifying start gave no interrupt or output change.");

    property p_one_shot_quiet;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && tcs_pkg::tcs_is_one_shot(mode))
        |=> !channel_interrupt_r[n] && !channel_timer_output_chg_r[n];
    endproperty
    a_one_shot_quiet: assert property (p_one_shot_quiet)
      else $error("One-count start drove interrupt or output.");

    property p_busy_ignored;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && counter_busy[n] && !start_behaviour_bit[n] &&
         tcs_pkg::tcs_is_one_shot(mode)) |=> !count_restart_r[n];
    endproperty
    a_busy_ignored: assert property (p_busy_ignored)
      else $error("Start during count was not ignored.");

    property p_retrigger;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && counter_busy[n] && start_behaviour_bit[n] &&
         mode == tcs_pkg::MODE_ONE_COUNT)
        |=> count_restart_r[n] && !channel_interrupt_r[n];
    endproperty
    a_retrigger: assert property (p_retrigger)
      else $error("One-count retrigger did not restart quietly.");

    property p_bad_mode;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && mode != tcs_pkg::MODE_INTERVAL &&
         mode != tcs_pkg::MODE_CAPTURE && mode != tcs_pkg::MODE_EVENT &&
         !tcs_pkg::tcs_is_one_shot(mode)) |=> !count_restart_r[n];
    endproperty
    a_bad_mode: assert property (p_bad_mode)
      else $error("Prohibited mode started the counter.");

    property p_cap_one_quiet;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && !start_behaviour_bit[n] &&
         mode == tcs_pkg::MODE_CAP_ONE)
        |=> !channel_interrupt_r[n] &&
            count_restart_r[n] == !$past(counter_busy[n]);
    endproperty
    a_cap_one_quiet: assert property (p_cap_one_quiet)
      else $error("Capture one-count start was not quiet.");

    property p_quiet_start;
      @(posedge clk_sys) disable iff (reset)
        (start_bits[n] && !start_behaviour_bit[n])
        |=> !channel_interrupt_r[n] && !channel_timer_output_chg_r[n];
    endproperty
    a_quiet_start: assert property (p_quiet_start)
      else $error("Quiet start drove interrupt or output.");

    property p_en_hold;
      @(posedge clk_sys) disable iff (reset)
        (!start_bits[n] && !stop_bits[n])
        |=> $stable(channel_enable_flag[n]);
    endproperty
    a_en_hold: assert property (p_en_hold)
      else $error("Enable flag moved without a trigger.");
  end

  // start actions
  // Interrupt and output change share one decision so they never disagree.
  assign restart_nxt = start_bits[7:0] & accept;
  assign irq_nxt     = restart_nxt & notify;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      channel_interrupt_r        <= 8'h00;
      channel_timer_output_chg_r <= 8'h00;
      count_restart_r            <= 8'h00;
    end else begin
      channel_interrupt_r        <= irq_nxt;
      channel_timer_output_chg_r <= irq_nxt;
      count_restart_r            <= restart_nxt;
    end
  end

  // overflow status has no write path
  assign word_addr = {cpu_addr[19:1], 1'b0};
  assign ovf_off   = word_addr - tcs_pkg::ADDR_OVF_CH0;
  assign ovf_idx   = ovf_off[3:1];

  always_comb begin
    rd_word = 16'h0000;
    if (word_addr >= tcs_pkg::ADDR_OVF_CH0 &&
        word_addr <= tcs_pkg::ADDR_OVF_CH7) begin
      rd_word = {15'h0000, ovf_flag[ovf_idx]};
    end else if (word_addr == tcs_pkg::ADDR_EN_STATUS) begin
      rd_word = en_r;
    end
    if (cpu_byte) begin
      rdata_nxt = cpu_addr[0] ? {8'h00, rd_word[15:8]}
                              : {8'h00, rd_word[7:0]};
    end else begin
      rdata_nxt = cpu_addr[0] ? 16'h0000 : rd_word;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpu_rdata_r <= tcs_pkg::RD_RESET;
    end else if (cpu_rd) begin
      cpu_rdata_r <= rdata_nxt;
    end
  end

  property p_trig_read_zero;
    @(posedge clk_sys) disable iff (reset)
      (cpu_rd && (word_addr == tcs_pkg::ADDR_START_TRIG ||
                  word_addr == tcs_pkg::ADDR_STOP_TRIG))
      |=> cpu_rdata_r == 16'h0000;
  endproperty
  a_trig_read_zero: assert property (p_trig_read_zero)
    else $error("Trigger register did not read as zero.");

  property p_en_read;
    @(posedge clk_sys) disable iff (reset)
      (cpu_rd && !cpu_byte && cpu_addr == tcs_pkg::ADDR_EN_STATUS)
      |=> cpu_rdata_r == $past(en_r);
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("Enable status word read wrong.");

  property p_en_reserved;
    @(posedge clk_sys) disable iff (reset)
      (en_r & ~tcs_pkg::TRIG_MASK) == 16'h0000;
  endproperty
  a_en_reserved: assert property (p_en_reserved)
    else $error("Reserved enable status bit set.");

  property p_ovf_read;
    @(posedge clk_sys) disable iff (reset)
      (cpu_rd && !cpu_byte && cpu_addr == tcs_pkg::ADDR_OVF_CH0)
      |=> cpu_rdata_r == {15'h0000, $past(ovf_flag[0])};
  endproperty
  a_ovf_read: assert property (p_ovf_read)
    else $error("Overflow status word read wrong.");

  property p_ovf_byte_read;
    @(posedge clk_sys) disable iff (reset)
      (cpu_rd && cpu_byte && cpu_addr == tcs_pkg::ADDR_OVF_CH7)
      |=> cpu_rdata_r == {15'h0000, $past(ovf_flag[7])};
  endproperty
  a_ovf_byte_read: assert property (p_ovf_byte_read)
    else $error("Overflow status byte read wrong.");

  property p_upper_quiet;
    @(posedge clk_sys) disable iff (reset)
      (start_bits[7:0] == 8'h00)
      |=> count_restart_r == 8'h00 && channel_interrupt_r == 8'h00;
  endproperty
  a_upper_quiet: assert property (p_upper_quiet)
    else $error("Upper-half trigger produced a start pulse.");

  property p_upper_hold;
    @(posedge clk_sys) disable iff (reset)
      (!start_bits[tcs_pkg::UPPER_CH1_BIT] &&
       !stop_bits[tcs_pkg::UPPER_CH1_BIT])
      |=> $stable(upper_half_enable_ch1);
  endproperty
  a_upper_hold: assert property (p_upper_hold)
    else $error("Upper-half flag moved without a trigger.");

  property p_rdata_hold;
    @(posedge clk_sys) disable iff (reset)
      !cpu_rd |=> $stable(cpu_rdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

  c_start_irq: cover property (@(posedge clk_sys) disable iff (reset)
    |channel_interrupt_r);
  c_retrigger: cover property (@(posedge clk_sys) disable iff (reset)
    |(count_restart_r & counter_busy));
  c_upper_half: cover property (@(posedge clk_sys) disable iff (reset)
    upper_half_enable_ch1 && !channel_enable_flag[1]);
  c_stop_after_start: cover property (@(posedge clk_sys) disable iff (reset)
    channel_enable_flag[0] ##1 !channel_enable_flag[0]);
endmodule : tcs_top
`default_nettype wire

/* testbench/timer_channel_start_status_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %0t %s", $time, msg); \
    end \
  end
module timer_channel_start_status_bench;
  logic        clk_sys;
  logic        reset;
  logic [19:0] cpu_addr;
  logic        cpu_wr;
  logic        cpu_rd;
  logic        cpu_byte;
  logic [15:0] cpu_wdata;
  logic [15:0] cpu_rdata_r;
  logic [7:0]  op_mode_bit2;
  logic [7:0]  op_mode_bit1;
  logic [7:0]  op_mode_bit0;
  logic [7:0]  start_behaviour_bit;
  logic [7:0]  counter_busy;
  logic [7:0]  capture_event;
  logic [7:0]  overflow_event;
  logic [7:0]  channel_enable_flag;
  logic        upper_half_enable_ch1;
  logic        upper_half_enable_ch3;
  logic [7:0]  channel_interrupt_r;
  logic [7:0]  channel_timer_output_chg_r;
  logic [7:0]  count_restart_r;
  logic [15:0] q;
  int          error_cnt;
  int          n_tests;

  tcs_top dut (
    .clk_sys                   (clk_sys),
    .reset                     (reset),
    .cpu_addr                  (cpu_addr),
    .cpu_wr                    (cpu_wr),
    .cpu_rd                    (cpu_rd),
    .cpu_byte                  (cpu_byte),
    .cpu_wdata                 (cpu_wdata),
    .cpu_rdata_r               (cpu_rdata_r),
    .op_mode_bit2              (op_mode_bit2),
    .op_mode_bit1              (op_mode_bit1),
    .op_mode_bit0              (op_mode_bit0),
    .start_behaviour_bit       (start_behaviour_bit),
    .counter_busy              (counter_busy),
    .capture_event             (capture_event),
    .overflow_event            (overflow_event),
    .channel_enable_flag       (channel_enable_flag),
    .upper_half_enable_ch1     (upper_half_enable_ch1),
    .upper_half_enable_ch3     (upper_half_enable_ch3),
    .channel_interrupt_r       (channel_interrupt_r),
    .channel_timer_output_chg_r(channel_timer_output_chg_r),
    .count_restart_r           (count_restart_r)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // All bus tasks end one unit after an edge, so the next task can drive.
  task automatic wr(input logic [19:0] a, input logic b, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cpu_addr  = a;
    cpu_byte  = b;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic b,
                    output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cpu_addr = a;
    cpu_byte = b;
    cpu_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_rd = 1'b0;
    d      = cpu_rdata_r;
  endtask : rd

  task automatic pulse(input logic [7:0] cap, input logic [7:0] ovf);
    @(posedge clk_sys);
    #1;
    capture_event  = cap;
    overflow_event = ovf;
    @(posedge clk_sys);
    #1;
    capture_event  = 8'h00;
    overflow_event = 8'h00;
  endtask : pulse

  task automatic set_mode(input int ch, input logic [2:0] m,
                          input logic beh, input logic busy);
    op_mode_bit2[ch]        = m[2];
    op_mode_bit1[ch]        = m[1];
    op_mode_bit0[ch]        = m[0];
    start_behaviour_bit[ch] = beh;
    counter_busy[ch]        = busy;
  endtask : set_mode

  task automatic t_reset();
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b0, q);
    `CHK(q, 16'h0000, "ovf ch0 reset")
    rd(tcs_pkg::ADDR_OVF_CH7, 1'b0, q);
    `CHK(q, 16'h0000, "ovf ch7 reset")
    rd(tcs_pkg::ADDR_EN_STATUS, 1'b0, q);
    `CHK(q, 16'h0000, "enable reset")
    `CHK(channel_interrupt_r, 8'h00, "interrupt at reset")
    $display("t_reset done");
  endtask : t_reset

  // Mode 1 stands for the prohibited codes: the enable sets, nothing starts.
  task automatic t_start();
    logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h1};
    int         ch;
    logic [2:0] m;
    logic       rs;
    logic       nt;
    logic [7:0] bn;
    for (int i = 0; i < 24; i++) begin
      ch = i % 8;
      m  = modes[i / 4];
      bn = 8'h01 << ch;
      rs = (m == 3'h0 || m == 3'h2 || m == 3'h3) ||
           ((m == 3'h4 || m == 3'h6) && (!i[1] || i[0]));
      nt = (m == 3'h0 || m == 3'h2) && i[0];
      set_mode(ch, m, i[0], i[1]);
      wr(tcs_pkg::ADDR_START_TRIG, 1'b0, {8'h00, bn});
      `CHK(channel_enable_flag, bn, "enable not set")
      `CHK(count_restart_r, rs ? bn : 8'h00, "restart")
      `CHK(channel_interrupt_r, nt ? bn : 8'h00, "interrupt")
      `CHK(channel_timer_output_chg_r, nt ? bn : 8'h00, "output")
      @(posedge clk_sys);
      #1;
      `CHK(channel_interrupt_r, 8'h00, "interrupt held")
      `CHK(count_restart_r, 8'h00, "restart held")
      wr(tcs_pkg::ADDR_STOP_TRIG, 1'b0, {8'h00, bn});
      `CHK(channel_enable_flag, 8'h00, "enable not cleared")
    end
    counter_busy = 8'h00;
    $display("t_start done");
  endtask : t_start

  task automatic t_enable();
    wr(tcs_pkg::ADDR_START_TRIG, 1'b0, 16'h0A00);
    `CHK({upper_half_enable_ch3, upper_half_enable_ch1}, 2'b11, "upper")
    `CHK(channel_enable_flag, 8'h00, "lower set by upper")
    `CHK(count_restart_r, 8'h00, "upper restart")
    wr(tcs_pkg::ADDR_START_TRIG, 1'b1, 16'h0002);
    `CHK(channel_enable_flag, 8'h02, "lower half")
    rd(tcs_pkg::ADDR_EN_STATUS, 1'b0, q);
    `CHK(q, 16'h0A02, "enable word")
    rd(tcs_pkg::ADDR_EN_STATUS | tcs_pkg::ADDR_HI_BYTE, 1'b1, q);
    `CHK(q, 16'h000A, "enable high byte")
    rd(tcs_pkg::ADDR_START_TRIG, 1'b0, q);
    `CHK(q, 16'h0000, "trigger reads")
    wr(tcs_pkg::ADDR_EN_STATUS, 1'b0, 16'h00F0);
    rd(tcs_pkg::ADDR_EN_STATUS, 1'b1, q);
    `CHK(q, 16'h0002, "enable low byte")
    wr(tcs_pkg::ADDR_STOP_TRIG | tcs_pkg::ADDR_HI_BYTE, 1'b1, 16'h0002);
    `CHK({upper_half_enable_ch3, upper_half_enable_ch1}, 2'b10, "stop")
    wr(tcs_pkg::ADDR_STOP_TRIG, 1'b0, 16'h0AFF);
    rd(tcs_pkg::ADDR_EN_STATUS, 1'b0, q);
    `CHK(q, 16'h0000, "stop all")
    $display("t_enable done");
  endtask : t_enable

  task automatic t_overflow();
    set_mode(0, tcs_pkg::MODE_CAPTURE, 1'b0, 1'b0);
    set_mode(3, tcs_pkg::MODE_INTERVAL, 1'b0, 1'b0);
    set_mode(7, tcs_pkg::MODE_CAP_ONE, 1'b0, 1'b0);
    pulse(8'h00, 8'h89);
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b0, q);
    `CHK(q, 16'h0000, "flag before capture")
    pulse(8'h89, 8'h00);
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b0, q);
    `CHK(q, 16'h0001, "ovf ch0")
    rd(tcs_pkg::ADDR_OVF_CH7, 1'b0, q);
    `CHK(q, 16'h0001, "ovf ch7")
    rd(tcs_pkg::ADDR_OVF_CH0 + 20'h00006, 1'b0, q);
    `CHK(q, 16'h0000, "ovf interval mode")
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b1, q);
    `CHK(q, 16'h0001, "ovf low byte")
    rd(tcs_pkg::ADDR_OVF_CH0 | tcs_pkg::ADDR_HI_BYTE, 1'b1, q);
    `CHK(q, 16'h0000, "ovf high byte")
    wr(tcs_pkg::ADDR_OVF_CH0, 1'b0, 16'h0000);
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b0, q);
    `CHK(q, 16'h0001, "ovf written")
    pulse(8'h81, 8'h80);
    rd(tcs_pkg::ADDR_OVF_CH7, 1'b0, q);
    `CHK(q, 16'h0001, "same cycle overflow")
    rd(tcs_pkg::ADDR_OVF_CH7, 1'b1, q);
    `CHK(q, 16'h0001, "ovf ch7 low byte")
    rd(tcs_pkg::ADDR_OVF_CH0, 1'b0, q);
    `CHK(q, 16'h0000, "ovf not cleared")
    rd(20'hF01C0, 1'b0, q);
    `CHK(q, 16'h0000, "unmapped read")
    wr(tcs_pkg::ADDR_START_TRIG, 1'b0, 16'h00FF);
    reset = 1'b1;
    @(posedge clk_sys);
    #1;
    reset = 1'b0;
    rd(tcs_pkg::ADDR_OVF_CH7, 1'b0, q);
    `CHK(q, 16'h0000, "ovf after reset")
    `CHK(channel_enable_flag, 8'h00, "enable after reset")
    $display("t_overflow done");
  endtask : t_overflow

  // The whole run needs about 200 cycles; the limit leaves a wide margin.
  initial begin
    #50000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    error_cnt           = 0;
    n_tests             = 0;
    reset               = 1'b1;
    cpu_addr            = 20'h00000;
    cpu_wr              = 1'b0;
    cpu_rd              = 1'b0;
    cpu_byte            = 1'b0;
    cpu_wdata           = 16'h0000;
    op_mode_bit2        = 8'h00;
    op_mode_bit1        = 8'h00;
    op_mode_bit0        = 8'h00;
    start_behaviour_bit = 8'h00;
    counter_busy        = 8'h00;
    capture_event       = 8'h00;
    overflow_event      = 8'h00;
    repeat (12) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_reset();
    t_start();
    t_enable();
    t_overflow();
    tally_and_finish();
  end
endmodule : timer_channel_start_status_bench
`default_nettype wire
